/* core/epv_port.sv */
/*
 Program/verify port of an on-chip code EPROM: pin mode decode, code array,
 key table, lock bits, watchdog option fuses, emulation float and a register
 slave for the watchdog view. Assumes pins are synchronous to aclk and held
 static by the programmer while a mode is applied.
*/
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
// What this block does
// - Address on ports 1 and 2, data on port 0; byte stored there.
// - Wider variant also uses port 2 bit 5 as an address bit.
// - In verify mode the addressed byte is driven onto port 0.
// - Verify byte is stored byte XNOR key selected by low five address bits.
// - Unprogrammed key bytes are all ones, so verify shows plain code.
// - Key table programmed with port 3 bit 6 low, addresses 0 to 1F.
// - No mode reads the key table out directly.
// - With lock bit two set, external code cannot read internal memory.
// - Lock bit two blocks code and key programming; lock bit one stays writable.
// - Both lock bits set also refuse verification.
// - Signature mode returns maker id at 0030 and part id at 0031.
// - Emulation floats port 0, weakly pulls the rest high until hardware reset.
// - After erasure every location reads all ones.
// - Unprogrammed watchdog fuses are zero: watchdog stays software controlled.
// - Fixed-on fuse enables the watchdog after every reset source.
// - Hardwired time fuse fixes the watchdog time; software cannot change it.
// - Operation chosen by static levels of reset, strobe, latch, supply, port bits.
`timescale 1ns/1ns
`default_nettype none

module epv_port #(
   parameter bit WIDE_PART = 1'b0,
   parameter logic [7:0] MAKER_ID = 8'h5a,
   parameter logic [7:0] PART_ID = 8'ha7
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rst_pin,
   input wire logic code_fetch_strobe,
   input wire logic latch_and_program_pulse,
   input wire logic external_fetch_and_supply_pin,
   input wire logic [7:0] p0_in,
   input wire logic [7:0] p1_in,
   input wire logic [7:0] p2_in,
   input wire logic port3_bit_six,
   input wire logic port3_bit_seven,
   input wire logic erase_req,
   input wire logic sw_reset_req,
   input wire logic wdog_reset_req,
   output logic [7:0] p0_out,
   output logic p0_oe,
   output logic weak_pullup_en,
   output logic ext_fetch_blocked,
   output logic wdog_enable,
   output logic [3:0] wdog_time
);
   // MAKER_ID and PART_ID defaults are arbitrary values
   localparam int CODE_AW = WIDE_PART ? epv_pkg::WIDE_AW : epv_pkg::BASE_AW;
   localparam int CODE_DEPTH = 1 << CODE_AW;

   logic [7:0] code_mem_r [CODE_DEPTH];
   logic [7:0] key_mem_r [epv_pkg::KEY_COUNT];
   logic lock1_r, lock2_r;
   logic [epv_pkg::FUSE_W-1:0] fuse_r;
   logic [25:0] setup_r;
   epv_pkg::epv_emu_t emu_r, emu_nxt;
   epv_pkg::epv_mode_t mode_w;

   wire logic [13:0] addr_full;
   wire logic [CODE_AW-1:0] addr_idx;
   wire logic [epv_pkg::KEY_AW-1:0] key_idx;
   wire logic [3:0] mode_sel;
   wire logic in_setup, vpp, latch, pulse_mode, changed, cnt_clear;
   wire logic pulse_fell, pulse_done;
   wire logic code_we, key_we, lock1_set, lock2_set, fuse_we, key_addr_ok;
   wire logic [7:0] rd_code, key_byte, verify_byte, sig_byte, fuse_byte;
   wire logic verify_locked, p0_oe_nxt;
   wire logic [7:0] p0_out_nxt;
   wire logic opt_en, fix_on, any_rst;
   wire logic [3:0] fuse_time;
   wire logic wdog_en_nxt;
   wire logic [3:0] wdog_time_nxt;
   wire logic bus_wr_en, wr_ok, rd_ok, ctrl_we;
   wire logic [31:0] bus_wr_addr, bus_wr_data, bus_rd_addr, rd_data, ctrl_word, status_word;
   wire logic [3:0] bus_wr_strb;

   // Pin-level mode decode; levels are static while a mode is applied
   assign latch = latch_and_program_pulse;
   assign vpp = external_fetch_and_supply_pin;
   assign in_setup = rst_pin & ~code_fetch_strobe;
   assign mode_sel = {p2_in[7], p2_in[6], port3_bit_seven, port3_bit_six};
   assign mode_w = !in_setup ? epv_pkg::EPV_IDLE :
      (mode_sel == epv_pkg::SEL_PROG_CODE && vpp) ? epv_pkg::EPV_PROG_CODE :
      (mode_sel == epv_pkg::SEL_PROG_KEY && vpp) ? epv_pkg::EPV_PROG_KEY :
      (mode_sel == epv_pkg::SEL_LOCK1 && vpp) ? epv_pkg::EPV_LOCK1 :
      (mode_sel == epv_pkg::SEL_LOCK2 && vpp) ? epv_pkg::EPV_LOCK2 :
      (mode_sel == epv_pkg::SEL_FUSE_PROG && vpp) ? epv_pkg::EPV_FUSE_PROG :
      (mode_sel == epv_pkg::SEL_VERIFY && latch) ? epv_pkg::EPV_VERIFY_CODE :
      (mode_sel == epv_pkg::SEL_SIGNATURE && latch) ? epv_pkg::EPV_SIGNATURE :
      (mode_sel == epv_pkg::SEL_FUSE_VERIFY && latch) ? epv_pkg::EPV_FUSE_VERIFY :
      epv_pkg::EPV_IDLE;

   // Extra address bit only on the wider variant
   assign addr_full = {(WIDE_PART ? p2_in[5] : 1'b0), p2_in[4:0], p1_in};
   assign addr_idx = addr_full[CODE_AW-1:0];
   assign key_idx = addr_full[epv_pkg::KEY_AW-1:0];
   assign key_addr_ok = (addr_full[13:epv_pkg::KEY_AW] == '0);

   // Any change of mode, address or data restarts the pulse count, so a
   // sequence split across two locations never completes a write
   assign pulse_mode = (mode_w == epv_pkg::EPV_PROG_CODE) || (mode_w == epv_pkg::EPV_PROG_KEY)
      || (mode_w == epv_pkg::EPV_LOCK1) || (mode_w == epv_pkg::EPV_LOCK2);
   assign changed = ({mode_w, addr_full, p0_in} != setup_r);
   assign cnt_clear = ~pulse_mode | changed;

   epv_pulse_count #(
      .NUM_PULSES(epv_pkg::NUM_PROG_PULSES)
   ) u_pulse (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(cnt_clear),
      .pulse_pin(latch),
      .fell(pulse_fell),
      .done(pulse_done)
   );

   // Lock bit two refuses code and key writes; lock bit one and fuses stay open
   assign code_we = pulse_done & (mode_w == epv_pkg::EPV_PROG_CODE) & ~lock2_r;
   assign key_we = pulse_done & (mode_w == epv_pkg::EPV_PROG_KEY) & ~lock2_r & key_addr_ok;
   assign lock1_set = pulse_done & (mode_w == epv_pkg::EPV_LOCK1);
   assign lock2_set = pulse_done & (mode_w == epv_pkg::EPV_LOCK2);
   assign fuse_we = pulse_fell & (mode_w == epv_pkg::EPV_FUSE_PROG);

   // Programming only clears bits, as an EPROM cell does
   always_ff @(posedge aclk) begin
      if (!aresetn || erase_req) begin
         for (int i = 0; i < CODE_DEPTH; i++) code_mem_r[i] <= epv_pkg::ERASED_BYTE;
      end else if (code_we) begin
         code_mem_r[addr_idx] <= code_mem_r[addr_idx] & p0_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || erase_req) begin
         for (int i = 0; i < epv_pkg::KEY_COUNT; i++) key_mem_r[i] <= epv_pkg::ERASED_BYTE;
      end else if (key_we) begin
         key_mem_r[key_idx] <= key_mem_r[key_idx] & p0_in;
      end
   end

   // Fuses survive erasure; only a power-up of the model clears them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock1_r <= 1'b0;
         lock2_r <= 1'b0;
         fuse_r <= epv_pkg::FUSE_RESET;
         setup_r <= '0;
      end else begin
         lock1_r <= ~erase_req & (lock1_r | lock1_set);
         lock2_r <= ~erase_req & (lock2_r | lock2_set);
         fuse_r <= fuse_we ? (fuse_r | p0_in[epv_pkg::FUSE_W-1:0]) : fuse_r;
         setup_r <= {mode_w, addr_full, p0_in};
      end
   end

   // Verify path: the key table only ever reaches port 0 through the XNOR
   assign rd_code = code_mem_r[addr_idx];
   assign key_byte = key_mem_r[key_idx];
   assign verify_byte = rd_code ~^ key_byte;
   assign verify_locked = lock1_r & lock2_r;
   assign sig_byte = (addr_full == epv_pkg::SIG_MAKER_ADDR) ? MAKER_ID :
      (addr_full == epv_pkg::SIG_PART_ADDR) ? PART_ID : epv_pkg::ERASED_BYTE;
   assign fuse_byte = {epv_pkg::FUSE_RSVD, fuse_r};
   assign p0_oe_nxt = (emu_r != epv_pkg::EPV_EMU_ON) &&
      (((mode_w == epv_pkg::EPV_VERIFY_CODE) && !verify_locked) ||
       (mode_w == epv_pkg::EPV_SIGNATURE) || (mode_w == epv_pkg::EPV_FUSE_VERIFY));
   assign p0_out_nxt = !p0_oe_nxt ? epv_pkg::ERASED_BYTE :
      (mode_w == epv_pkg::EPV_VERIFY_CODE) ? verify_byte :
      (mode_w == epv_pkg::EPV_SIGNATURE) ? sig_byte : fuse_byte;

   // Emulation entry: latch low while reset high and strobe high, then reset falls
   always_comb begin
      emu_nxt = emu_r;
      case (emu_r)
         epv_pkg::EPV_EMU_OFF: begin
            if (rst_pin && code_fetch_strobe && !latch) emu_nxt = epv_pkg::EPV_EMU_ARMED;
         end
         epv_pkg::EPV_EMU_ARMED: begin
            if (latch) emu_nxt = epv_pkg::EPV_EMU_OFF;
            else if (!rst_pin) emu_nxt = epv_pkg::EPV_EMU_ON;
         end
         epv_pkg::EPV_EMU_ON: begin
            if (rst_pin) emu_nxt = epv_pkg::EPV_EMU_OFF;
         end
         default: emu_nxt = epv_pkg::EPV_EMU_OFF;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         emu_r <= epv_pkg::EPV_EMU_OFF;
         p0_out <= epv_pkg::ERASED_BYTE;
         p0_oe <= 1'b0;
         weak_pullup_en <= 1'b0;
         ext_fetch_blocked <= 1'b0;
      end else begin
         emu_r <= emu_nxt;
         p0_out <= p0_out_nxt;
         p0_oe <= p0_oe_nxt;
         weak_pullup_en <= (emu_r == epv_pkg::EPV_EMU_ON);
         ext_fetch_blocked <= lock2_r;
      end
   end

   // Watchdog view: fuses override software when the option enable is set
   assign opt_en = fuse_r[epv_pkg::FUSE_OPT_EN_BIT];
   assign fix_on = fuse_r[epv_pkg::FUSE_FIX_ON_BIT];
   assign fuse_time = fuse_r[epv_pkg::FUSE_TIME_LSB +: epv_pkg::FUSE_TIME_W];
   assign any_rst = rst_pin | sw_reset_req | wdog_reset_req;
   assign ctrl_we = bus_wr_en & wr_ok & bus_wr_strb[0];
   assign wdog_en_nxt = (opt_en & fix_on) ? 1'b1 :
      any_rst ? 1'b0 : ctrl_we ? bus_wr_data[epv_pkg::CTRL_EN_BIT] : wdog_enable;
   assign wdog_time_nxt = opt_en ? fuse_time :
      any_rst ? epv_pkg::WDOG_TIME_RESET : ctrl_we ? bus_wr_data[epv_pkg::CTRL_TIME_LSB +: 4] : wdog_time;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_enable <= 1'b0;
         wdog_time <= epv_pkg::WDOG_TIME_RESET;
      end else begin
         wdog_enable <= wdog_en_nxt;
         wdog_time <= wdog_time_nxt;
      end
   end

   // Register decode; the status word is read-only and refuses writes
   assign wr_ok = (bus_wr_addr == epv_pkg::REG_WDOG_CTRL);
   assign rd_ok = (bus_rd_addr == epv_pkg::REG_WDOG_CTRL) || (bus_rd_addr == epv_pkg::REG_STATUS);
   assign ctrl_word = (32'(wdog_enable) << epv_pkg::CTRL_EN_BIT) | (32'(wdog_time) << epv_pkg::CTRL_TIME_LSB);
   assign status_word = (32'(fuse_r) << epv_pkg::STAT_FUSE_LSB) | (32'(lock1_r) << epv_pkg::STAT_LOCK1_BIT)
      | (32'(lock2_r) << epv_pkg::STAT_LOCK2_BIT) | (32'(emu_r == epv_pkg::EPV_EMU_ON) << epv_pkg::STAT_EMU_BIT)
      | (32'(mode_w) << epv_pkg::STAT_MODE_LSB);
   assign rd_data = (bus_rd_addr == epv_pkg::REG_STATUS) ? status_word : ctrl_word;

   epv_axil_slave u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_en(bus_wr_en),
      .wr_addr(bus_wr_addr),
      .wr_data(bus_wr_data),
      .wr_strb(bus_wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(bus_rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_code_write;
      code_we && !erase_req |=> code_mem_r[$past(addr_idx)] == ($past(rd_code) & $past(p0_in));
   endproperty
   a_code_write: assert property (p_code_write) else $error("code byte not stored");

   property p_code_locked;
      pulse_done && mode_w == epv_pkg::EPV_PROG_CODE && lock2_r && !erase_req
         |=> code_mem_r[$past(addr_idx)] == $past(rd_code);
   endproperty
   a_code_locked: assert property (p_code_locked) else $error("locked code byte changed");

   property p_key_write;
      key_we && !erase_req |=> key_mem_r[$past(key_idx)] == ($past(key_byte) & $past(p0_in));
   endproperty
   a_key_write: assert property (p_key_write) else $error("key byte not stored");

   property p_verify_out;
      mode_w == epv_pkg::EPV_VERIFY_CODE && !verify_locked && emu_r != epv_pkg::EPV_EMU_ON
         |=> p0_oe && p0_out == $past(rd_code ~^ key_byte);
   endproperty
   a_verify_out: assert property (p_verify_out) else $error("verify byte wrong");

   property p_verify_refused;
      mode_w == epv_pkg::EPV_VERIFY_CODE && lock1_r && lock2_r |=> !p0_oe;
   endproperty
   a_verify_refused: assert property (p_verify_refused) else $error("verify not refused");

   property p_signature;
      mode_w == epv_pkg::EPV_SIGNATURE && addr_full == epv_pkg::SIG_PART_ADDR |=> p0_oe && p0_out == PART_ID;
   endproperty
   a_signature: assert property (p_signature) else $error("part id wrong");

   property p_emu_float;
      (emu_r == epv_pkg::EPV_EMU_ON)[*2] |-> !p0_oe && weak_pullup_en;
   endproperty
   a_emu_float: assert property (p_emu_float) else $error("emulation float not held");

   property p_emu_entry;
      emu_r == epv_pkg::EPV_EMU_ARMED && !rst_pin && !latch |=> emu_r == epv_pkg::EPV_EMU_ON;
   endproperty
   a_emu_entry: assert property (p_emu_entry) else $error("emulation not entered");

   property p_fixed_on;
      opt_en && fix_on && any_rst |=> wdog_enable ##1 wdog_enable;
   endproperty
   a_fixed_on: assert property (p_fixed_on) else $error("watchdog not fixed on");

   property p_fixed_time;
      opt_en && ctrl_we |=> wdog_time == $past(fuse_time);
   endproperty
   a_fixed_time: assert property (p_fixed_time) else $error("hardwired time changed");

   property p_ext_block;
      lock2_r ##1 lock2_r |-> ext_fetch_blocked;
   endproperty
   a_ext_block: assert property (p_ext_block) else $error("external fetch not blocked");

   property p_erase;
      erase_req |=> code_mem_r[$past(addr_idx)] == epv_pkg::ERASED_BYTE && !lock2_r;
   endproperty
   a_erase: assert property (p_erase) else $error("erase incomplete");

   c_code_write: cover property (code_we);
   c_verify: cover property (p0_oe && mode_w == epv_pkg::EPV_VERIFY_CODE);
   c_emu: cover property (emu_r == epv_pkg::EPV_EMU_ON);
   c_lock_both: cover property (lock1_r && lock2_r);
endmodule

`default_nettype wire

/* core/epv_pkg.sv */
/*
 Shared constants and types of the EPROM program/verify port.
 Assumes nothing of its surroundings; every design file refers to it by name.
*/
package epv_pkg;
   localparam int NUM_PROG_PULSES = 25;
   localparam int KEY_AW = 5;
   localparam int KEY_COUNT = 32;
   localparam int BASE_AW = 13;
   localparam int WIDE_AW = 14;
   localparam int FULL_AW = 14;
   localparam logic [13:0] SIG_MAKER_ADDR = 14'h0030;
   localparam logic [13:0] SIG_PART_ADDR = 14'h0031;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int FUSE_W = 6;
   localparam logic [5:0] FUSE_RESET = 6'h00;
   localparam logic [1:0] FUSE_RSVD = 2'h0;
   localparam int FUSE_TIME_LSB = 0;
   localparam int FUSE_TIME_W = 4;
   localparam int FUSE_FIX_ON_BIT = 4;
   localparam int FUSE_OPT_EN_BIT = 5;
   // Levels of {p2_in[7:6], port3_bit_seven, port3_bit_six} per operation
   localparam logic [3:0] SEL_PROG_CODE = 4'hb;
   localparam logic [3:0] SEL_VERIFY = 4'h3;
   localparam logic [3:0] SEL_PROG_KEY = 4'ha;
   localparam logic [3:0] SEL_LOCK1 = 4'hf;
   localparam logic [3:0] SEL_LOCK2 = 4'hc;
   localparam logic [3:0] SEL_SIGNATURE = 4'h0;
   localparam logic [3:0] SEL_FUSE_PROG = 4'hd;
   localparam logic [3:0] SEL_FUSE_VERIFY = 4'h5;
   typedef enum logic [3:0] {
      EPV_IDLE = 4'b0000, EPV_PROG_CODE = 4'b0001, EPV_VERIFY_CODE = 4'b0010,
      EPV_PROG_KEY = 4'b0011, EPV_LOCK1 = 4'b0100, EPV_LOCK2 = 4'b0101,
      EPV_SIGNATURE = 4'b0110, EPV_FUSE_PROG = 4'b0111, EPV_FUSE_VERIFY = 4'b1000
   } epv_mode_t;
   typedef enum logic [1:0] {EPV_EMU_OFF = 2'b00, EPV_EMU_ARMED = 2'b01, EPV_EMU_ON = 2'b10} epv_emu_t;
   localparam logic [31:0] REG_WDOG_CTRL = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS = 32'h0000_0004;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CTRL_TIME_LSB = 0;
   localparam int CTRL_EN_BIT = 6;
   localparam logic [3:0] WDOG_TIME_RESET = 4'h0;
   localparam int STAT_FUSE_LSB = 0;
   localparam int STAT_LOCK1_BIT = 8;
   localparam int STAT_LOCK2_BIT = 9;
   localparam int STAT_EMU_BIT = 12;
   localparam int STAT_MODE_LSB = 16;
endpackage

/* core/epv_pulse_count.sv */
/*
 Counts completed low pulses on the program-pulse pin for one location.
 Assumes the pin is synchronous to aclk and idles high.
*/
`timescale 1ns/1ns
`default_nettype none

module epv_pulse_count #(
   parameter int NUM_PULSES = epv_pkg::NUM_PROG_PULSES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic pulse_pin,
   output logic fell,
   output logic done
);
   localparam int CW = $clog2(NUM_PULSES + 1);
   logic prev_r;
   logic [CW-1:0] cnt_r;
   logic rose;

   assign rose = ~prev_r & pulse_pin;
   assign fell = prev_r & ~pulse_pin;
   // Further pulses after the last are ignored, so one location gets one write
   assign done = rose & ~clear & (cnt_r == CW'(NUM_PULSES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b1;
         cnt_r <= '0;
      end else begin
         prev_r <= pulse_pin;
         if (clear) begin
            cnt_r <= '0;
         end else if (rose && cnt_r != CW'(NUM_PULSES)) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

/* core/epv_axil_slave.sv */
/*
 AXI4-Lite slave front end: takes write address and data in either order,
 presents one write and one read at a time to the register decode beside it.
 Assumes the decode answers rd_data/rd_ok/wr_ok combinationally.
*/
`timescale 1ns/1ns
`default_nettype none

module epv_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [31:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_held_r, w_held_r, ar_held_r;
   logic aw_hs, w_hs, b_hs, ar_hs, r_hs, rd_go;

   assign aw_hs = awvalid & awready;
   assign w_hs = wvalid & wready;
   assign b_hs = bvalid & bready;
   assign ar_hs = arvalid & arready;
   assign r_hs = rvalid & rready;
   assign wr_en = aw_held_r & w_held_r & ~bvalid;
   assign rd_go = ar_held_r & ~rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_held_r, w_held_r, ar_held_r} <= 3'h0;
         {awready, wready, arready, bvalid, rvalid} <= 5'h00;
         {bresp, rresp} <= 4'h0;
         {wr_addr, wr_data, rd_addr, rdata} <= 128'h0;
         wr_strb <= 4'h0;
      end else begin
         awready <= b_hs | ~(aw_held_r | aw_hs);
         wready <= b_hs | ~(w_held_r | w_hs);
         arready <= r_hs | ~(ar_held_r | ar_hs);
         if (aw_hs) begin
            aw_held_r <= 1'b1;
            wr_addr <= awaddr;
         end
         if (w_hs) begin
            w_held_r <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? epv_pkg::RESP_OKAY : epv_pkg::RESP_SLVERR;
         end
         if (b_hs) begin
            bvalid <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
         end
         if (ar_hs) begin
            ar_held_r <= 1'b1;
            rd_addr <= araddr;
         end
         if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_data : 32'h0000_0000;
            rresp <= rd_ok ? epv_pkg::RESP_OKAY : epv_pkg::RESP_SLVERR;
         end
         if (r_hs) begin
            rvalid <= 1'b0;
            ar_held_r <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

/* dv/epv_prog.sv */
/*
 Programmer model that drives the port pins.
 Assumes aclk from the bench; pins change only right after rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module epv_prog (
   input wire logic aclk,
   output logic rst_pin,
   output logic code_fetch_strobe,
   output logic latch_and_program_pulse,
   output logic external_fetch_and_supply_pin,
   output logic [7:0] p0_in,
   output logic [7:0] p1_in,
   output logic [7:0] p2_in,
   output logic port3_bit_six,
   output logic port3_bit_seven
);
   initial begin
      {rst_pin, external_fetch_and_supply_pin, latch_and_program_pulse} = 3'h7;
      {code_fetch_strobe, p0_in, p1_in, p2_in, port3_bit_six, port3_bit_seven} = 27'h0;
   end
   // Reset high, strobe low, supply high; mode bits set with the latch pin high
   task setup(input logic [3:0] sel, input logic [13:0] a, input logic [7:0] d);
      @(posedge aclk);
      {p2_in, p1_in, port3_bit_seven, port3_bit_six, p0_in} <= {sel[3:2], a, sel[1:0], d};
   endtask
   // One cycle low, one high: far shorter than the real pulse, the port does not time it
   task burst(input int n);
      repeat (n) begin
         @(posedge aclk) latch_and_program_pulse <= 1'b0;
         @(posedge aclk) latch_and_program_pulse <= 1'b1;
      end
      repeat (2) @(posedge aclk);
   endtask
   // Latch low with reset and strobe high, then reset falls; reset high leaves
   task emulate(input logic enter);
      @(posedge aclk) {rst_pin, code_fetch_strobe, latch_and_program_pulse} <= enter ? 3'h6 : 3'h5;
      if (enter) @(posedge aclk) rst_pin <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
/*
 Self-checking bench: AXI4-Lite tasks and the programmer model on the pins.
 Assumes the core package, the design and epv_prog are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [7:0] MAKER = 8'h5a, PART = 8'ha7; // Arbitrary identity values
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic sw_reset_req = 0, erase_req = 0, wdog_reset_req = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
   logic [3:0] wstrb = 4'hf, wdog_time;
   logic [1:0] bresp, rresp, rs;
   logic awready, wready, bvalid, arready, rvalid, rst_pin, code_fetch_strobe, latch_and_program_pulse;
   logic external_fetch_and_supply_pin, port3_bit_six, port3_bit_seven, p0_oe, weak_pullup_en;
   logic ext_fetch_blocked, wdog_enable;
   logic [7:0] p0_in, p1_in, p2_in, p0_out;
   wire [7:0] p0_bus = (p0_oe === 1'b1) ? p0_out : 8'hff;
   int errors = 0, checked = 0;
   initial forever #5 aclk = ~aclk; // Device oscillator
   epv_prog prog (.aclk, .rst_pin, .code_fetch_strobe, .latch_and_program_pulse,
      .external_fetch_and_supply_pin, .p0_in, .p1_in, .p2_in, .port3_bit_six, .port3_bit_seven);
   epv_port #(.MAKER_ID(MAKER), .PART_ID(PART)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .rst_pin, .code_fetch_strobe, .latch_and_program_pulse, .external_fetch_and_supply_pin, .p0_in,
      .p1_in, .p2_in, .port3_bit_six, .port3_bit_seven, .erase_req, .sw_reset_req, .wdog_reset_req, .p0_out,
      .p0_oe, .weak_pullup_en, .ext_fetch_blocked, .wdog_enable, .wdog_time);
   task tally_and_finish;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wait_ok(input int n);
      if (n >= 50) begin
         chk("bus answer", 32'h1, 32'h0);
         tally_and_finish;
      end
   endtask
   task axw(input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rs = bresp;
      bready <= 1'b0;
      wait_ok(n);
   endtask
   task axr(input logic [31:0] a);
      int n;
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      {rd, rs} = {rdata, rresp};
      rready <= 1'b0;
      wait_ok(n);
   endtask
   task vfy(input logic [3:0] sel, input logic [13:0] a, input logic [7:0] exp);
      prog.setup(sel, a, 8'h00);
      repeat (2) @(posedge aclk);
      chk("port 0", {24'h0, exp}, {24'h0, p0_bus});
   endtask
   task pgm(input logic [3:0] sel, input logic [13:0] a, input logic [7:0] d, input int n);
      prog.setup(sel, a, d);
      prog.burst(n);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(epv_pkg::REG_STATUS);
      chk("status", 32'h0, rd & 32'hffff);
      axr(32'h8);
      chk("rresp", {30'h0, epv_pkg::RESP_SLVERR}, {30'h0, rs});
      $display("test registers done");
      vfy(epv_pkg::SEL_VERIFY, 14'h0123, 8'hff);
      pgm(epv_pkg::SEL_PROG_CODE, 14'h0123, 8'h3c, 24);
      vfy(epv_pkg::SEL_VERIFY, 14'h0123, 8'hff);
      pgm(epv_pkg::SEL_PROG_CODE, 14'h0123, 8'h3c, 25);
      vfy(epv_pkg::SEL_VERIFY, 14'h0123, 8'h3c);
      pgm(epv_pkg::SEL_PROG_KEY, 14'h0003, 8'h0f, 25);
      vfy(epv_pkg::SEL_VERIFY, 14'h0123, 8'hcc);
      vfy(epv_pkg::SEL_VERIFY, 14'h0003, 8'h0f);
      vfy(epv_pkg::SEL_SIGNATURE, epv_pkg::SIG_MAKER_ADDR, MAKER);
      vfy(epv_pkg::SEL_SIGNATURE, epv_pkg::SIG_PART_ADDR, PART);
      $display("test program and verify done");
      pgm(epv_pkg::SEL_LOCK2, 14'h0, 8'h0, 25);
      pgm(epv_pkg::SEL_PROG_CODE, 14'h0124, 8'h00, 25);
      pgm(epv_pkg::SEL_PROG_KEY, 14'h0004, 8'h00, 25);
      vfy(epv_pkg::SEL_VERIFY, 14'h0124, 8'hff);
      chk("ext fetch blocked", 32'h1, {31'h0, ext_fetch_blocked});
      pgm(epv_pkg::SEL_LOCK1, 14'h0, 8'h0, 25);
      vfy(epv_pkg::SEL_VERIFY, 14'h0123, 8'hff);
      chk("p0 oe", 32'h0, {31'h0, p0_oe});
      axr(epv_pkg::REG_STATUS);
      chk("status", 32'h300, rd & 32'hffff);
      $display("test lock bits done");
      @(posedge aclk) erase_req <= 1'b1;
      @(posedge aclk) erase_req <= 1'b0;
      vfy(epv_pkg::SEL_VERIFY, 14'h0123, 8'hff);
      chk("p0 oe", 32'h1, {31'h0, p0_oe});
      prog.emulate(1'b1);
      chk("pullup", 32'h1, {31'h0, weak_pullup_en});
      axw(epv_pkg::REG_WDOG_CTRL, 32'h47);
      chk("wdog", 32'h17, {27'h0, wdog_enable, wdog_time});
      prog.emulate(1'b0);
      chk("pullup", 32'h0, {31'h0, weak_pullup_en});
      chk("wdog", 32'h0, {27'h0, wdog_enable, wdog_time});
      pgm(epv_pkg::SEL_FUSE_PROG, 14'h0, 8'h35, 1);
      vfy(epv_pkg::SEL_FUSE_VERIFY, 14'h0, 8'h35);
      @(posedge aclk) {sw_reset_req, wdog_reset_req} <= 2'h3;
      @(posedge aclk) {sw_reset_req, wdog_reset_req} <= 2'h0;
      repeat (2) @(posedge aclk);
      chk("wdog", 32'h15, {27'h0, wdog_enable, wdog_time});
      axw(epv_pkg::REG_WDOG_CTRL, 32'h2);
      chk("bresp", {30'h0, epv_pkg::RESP_OKAY}, {30'h0, rs});
      axr(epv_pkg::REG_WDOG_CTRL);
      chk("wdog ctrl", 32'h45, rd & 32'h4f);
      $display("test watchdog fuses done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
